// File: abs_position_readout_control.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module abs_position_readout_control
  import abs_readout_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Amplifier side
  input  wire logic [1:0]  abs_data_in,
  input  wire logic        send_ready_in,
  output logic             servo_enable_output_out,
  output logic             transfer_mode_out,
  output logic             data_request_out,
  // Status and interrupt
  output logic             op_complete_flag_out,
  output logic             irq_out
);
  import abs_readout_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  read_state_type          state;
  read_state_type          next_state;
  logic                    activate;
  logic [5:0]              step;
  logic [31:0]             position;
  logic [IRQ_WIDTH-1:0]    irq_status;
  logic [IRQ_WIDTH-1:0]    irq_enable;
  logic [WORD_BITS-1:0]    word;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire bus_wr     = bus_req && wb_we_in && ce_in;
  // Only the low byte lane holds writable bits
  wire lane_wr    = bus_wr && wb_sel_in[0];
  wire hit_ctrl   = wb_adr_in == CTRL_OFFSET;
  wire hit_status = wb_adr_in == STATUS_OFFSET;
  wire hit_pos    = wb_adr_in == POSITION_OFFSET;
  wire hit_istat  = wb_adr_in == IRQ_STATUS_OFFSET;
  wire hit_ien    = wb_adr_in == IRQ_ENABLE_OFFSET;
  wire hit_iclr   = wb_adr_in == IRQ_CLEAR_OFFSET;
  wire wr_ctrl    = lane_wr && hit_ctrl;
  wire wr_enable  = lane_wr && hit_ien;
  wire wr_clear   = lane_wr && hit_iclr;
  wire busy       = state != ST_IDLE && state != ST_HOLD;

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  logic [31:0]             ctrl_word;
  logic [31:0]             status_word;

  always_comb
  begin
    ctrl_word                    = 32'h0000_0000;
    ctrl_word[CTRL_ACTIVATE_BIT] = activate;
  end

  always_comb
  begin
    status_word                 = 32'h0000_0000;
    status_word[STAT_BUSY_BIT]  = busy;
    status_word[STAT_DONE_BIT]  = op_complete_flag_out;
    status_word[STAT_SERVO_BIT] = servo_enable_output_out;
    status_word[STAT_MODE_BIT]  = transfer_mode_out;
  end

  // Unmapped and write-only offsets read back as zero
  wire [31:0] read_mux =
    hit_ctrl   ? ctrl_word :
    hit_status ? status_word :
    hit_pos    ? position :
    hit_istat  ? 32'(irq_status) :
    hit_ien    ? 32'(irq_enable) :
    32'h0000_0000;

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  wire last_step  = step == 6'(STEP_COUNT - 1);
  wire take_pair  = state == ST_REQ && send_ready_in;
  wire step_done  = state == ST_WAIT_LOW && !send_ready_in;
  wire finish     = step_done && last_step;
  wire abort      = !activate && busy;
  wire clr_word   = state == ST_IDLE;
  logic [IRQ_WIDTH-1:0]    irq_events;

  // No stall supervision here; a hung exchange just stays busy
  always_comb
  begin
    irq_events                = '0;
    irq_events[IRQ_DONE_BIT]  = finish;
    irq_events[IRQ_ABORT_BIT] = abort;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:     if (activate) next_state = ST_REQ;
      ST_REQ:      if (take_pair) next_state = ST_WAIT_LOW;
      ST_WAIT_LOW: if (!send_ready_in) next_state = last_step ? ST_HOLD : ST_REQ;
      ST_HOLD:     next_state = ST_HOLD;
      default:     next_state = ST_IDLE;
    endcase
    if (!activate)
      next_state = ST_IDLE;
  end

  // ----------------------------------------
  // Word collector
  // ----------------------------------------
  abs_shift_collect #(
    .WIDTH (WORD_BITS)
  ) u_collect (
    .mclk_in  (mclk_in),
    .ce_in    (ce_in),
    .clear_in (clr_word),
    .shift_in (take_pair),
    .pair_in  (abs_data_in),
    .word_out (word)
  );

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state      <= ST_IDLE;
      step       <= 6'h00;
      activate   <= 1'b0;
      irq_enable <= '0;
    end
    else if (ce_in)
    begin
      state <= next_state;
      if (wr_ctrl)
        activate <= wb_dat_in[CTRL_ACTIVATE_BIT];
      if (wr_enable)
        irq_enable <= wb_dat_in[IRQ_WIDTH-1:0];
      if (state == ST_IDLE)
        step <= 6'h00;
      else if (step_done)
        step <= step + 6'h01;
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  // Pins follow state so they come from flops
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      servo_enable_output_out <= 1'b0;
      transfer_mode_out       <= 1'b0;
      data_request_out        <= 1'b0;
      op_complete_flag_out    <= 1'b0;
      position                <= POSITION_RESET;
    end
    else if (ce_in)
    begin
      servo_enable_output_out <= next_state != ST_IDLE;
      transfer_mode_out       <= next_state == ST_REQ || next_state == ST_WAIT_LOW;
      data_request_out        <= next_state == ST_REQ;
      op_complete_flag_out    <= next_state == ST_HOLD;
      if (finish)
        position <= word[DATA_BITS-1:0];
    end
  end

  // ----------------------------------------
  // Interrupts and bus answer
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      irq_status <= '0;
    else if (ce_in)
      irq_status <= (irq_status & ~(wr_clear ? wb_dat_in[IRQ_WIDTH-1:0] : '0)) | irq_events;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      irq_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? read_mux : 32'h0000_0000;
      irq_out    <= |(irq_status & irq_enable);
    end
  end
endmodule
`default_nettype wire

// File: abs_readout_pkg.sv
package abs_readout_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] POSITION_OFFSET   = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ACTIVATE_BIT   = 0;
  localparam int STAT_BUSY_BIT       = 0;
  localparam int STAT_DONE_BIT       = 1;
  localparam int STAT_SERVO_BIT      = 2;
  localparam int STAT_MODE_BIT       = 3;
  localparam int IRQ_DONE_BIT        = 0;
  localparam int IRQ_ABORT_BIT       = 1;
  localparam int IRQ_WIDTH           = 2;

  // ----------------------------------------
  // Reset values and transfer figures
  // ----------------------------------------
  localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
  localparam int          DATA_BITS      = 32;
  localparam int          CHECK_BITS     = 6;
  localparam int          WORD_BITS      = DATA_BITS + CHECK_BITS;
  localparam int          STEP_COUNT     = WORD_BITS / 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT_LOW,
    ST_HOLD
  } read_state_type;

endpackage

// File: abs_shift_collect.sv
`timescale 1ns/1ps
`default_nettype none
module abs_shift_collect
  import abs_readout_pkg::*;
#(
  parameter int WIDTH = 38
)
(
  input  wire logic             mclk_in,
  input  wire logic             ce_in,
  input  wire logic             clear_in,
  input  wire logic             shift_in,
  input  wire logic [1:0]       pair_in,
  output logic      [WIDTH-1:0] word_out
);
  // ----------------------------------------
  // Two-bit collector, first pair lands lowest
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (ce_in && clear_in)
      word_out <= '0;
    else if (ce_in && shift_in)
      word_out <= {pair_in, word_out[WIDTH-1:2]};
  end
endmodule
`default_nettype wire

// File: abs_readout_checker.sv
`timescale 1ns/1ps
`default_nettype none
module abs_readout_checker (
  input wire logic mclk_in, rst_in, ce_in, wb_cyc_in, wb_stb_in, wb_ack_out, send_ready_in,
  input wire logic servo_enable_output_out, transfer_mode_out, data_request_out, op_complete_flag_out
);
  // Frozen cycles carry no obligations
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in || !ce_in);
  property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack1; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack1: assert property (p_ack1) else $error("ack long");
  property p_req; data_request_out |-> transfer_mode_out && servo_enable_output_out; endproperty
  a_req: assert property (p_req) else $error("req alone");
  property p_fall; data_request_out && send_ready_in |=> !data_request_out; endproperty
  a_fall: assert property (p_fall) else $error("req stuck");
  property p_hold; data_request_out && !send_ready_in |=> data_request_out || !servo_enable_output_out; endproperty
  a_hold: assert property (p_hold) else $error("req lost");
  property p_wait; !data_request_out && send_ready_in |=> !data_request_out; endproperty
  a_wait: assert property (p_wait) else $error("req early");
  property p_done; op_complete_flag_out |-> servo_enable_output_out && !transfer_mode_out && !data_request_out; endproperty
  a_done: assert property (p_done) else $error("done bad");
  property p_drop; $fell(servo_enable_output_out) |-> !transfer_mode_out && !op_complete_flag_out; endproperty
  a_drop: assert property (p_drop) else $error("drop bad");
  c_step: cover property (data_request_out && send_ready_in);
  c_done: cover property ($rose(op_complete_flag_out));
  c_abort: cover property ($fell(transfer_mode_out) && !op_complete_flag_out);
endmodule
bind abs_position_readout_control abs_readout_checker chk_i (.mclk_in, .rst_in, .ce_in, .wb_cyc_in, .wb_stb_in,
  .wb_ack_out, .send_ready_in, .servo_enable_output_out, .transfer_mode_out, .data_request_out,
  .op_complete_flag_out);
`default_nettype wire

// File: abs_amp_model.sv
`timescale 1ns/1ps
`default_nettype none
module abs_amp_model (
  input  wire logic        mclk_in,
  input  wire logic        son_in,
  input  wire logic        req_in,
  input  wire logic [37:0] word_in,
  input  wire logic [3:0]  lag_in,
  output logic             rdy_out,
  output logic [1:0]       dat_out
);
  logic [5:0] idx = 6'h00;
  logic [3:0] cnt = 4'h0;
  initial rdy_out = 1'b0;
  initial dat_out = 2'h0;
  // Lag of 4'hf never answers: a stalled amplifier
  always @(posedge mclk_in)
  begin
    if (!rdy_out) dat_out <= ~dat_out; // Idle lines toggle each cycle instead of holding stale data
    if (!son_in)
    begin
      idx <= 6'h00;
      cnt <= 4'h0;
      rdy_out <= 1'b0;
    end
    else if (req_in && !rdy_out && lag_in != 4'hf)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag_in)
      begin
        rdy_out <= 1'b1;
        dat_out <= word_in[idx +: 2];
        cnt <= 4'h0;
      end
    end
    else if (!req_in && rdy_out)
    begin
      rdy_out <= 1'b0;
      idx <= idx + 6'h02;
    end
  end
endmodule
`default_nettype wire

// File: abs_position_readout_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module abs_position_readout_control_tb_top;
  import abs_readout_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, rd;
  logic [37:0] word = 38'h00_0000_0000;
  logic [3:0] lag = 4'h0;
  logic ack, servo_enable_output, mode, req, flag, irq, rdy;
  logic [1:0] pair;
  logic [3:0] snap;
  int num_errors = 0, n_compared = 0;
  always #5 mclk_in = ~mclk_in;
  abs_position_readout_control uut (.mclk_in, .rst_in, .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .abs_data_in(pair), .send_ready_in(rdy), .servo_enable_output_out(servo_enable_output), .transfer_mode_out(mode),
    .data_request_out(req), .op_complete_flag_out(flag), .irq_out(irq));
  abs_amp_model amp (.mclk_in, .son_in(servo_enable_output), .req_in(req), .word_in(word), .lag_in(lag), .rdy_out(rdy),
    .dat_out(pair));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge mclk_in);
    while (ack !== 1'b1) @(posedge mclk_in);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200_000;
    num_errors++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'h0ea0_14f3));
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    rdchk(POSITION_OFFSET, POSITION_RESET);
    rdchk(8'h20, 32'h0000_0000);
    bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0003);
    repeat (3)
    begin
      word <= 38'({$urandom(), $urandom()});
      lag <= 4'($urandom() % 4);
      bus(1'b1, CTRL_OFFSET, 32'h0000_0001);
      repeat (4) @(posedge mclk_in);
      chk({30'h0, servo_enable_output, mode}, 32'h0000_0003);
      // Freeze mid transfer; pins must hold and the exchange resume
      ce <= 1'b0;
      @(posedge mclk_in);
      snap = {servo_enable_output, mode, req, flag};
      repeat (6) @(posedge mclk_in);
      chk({28'h0, servo_enable_output, mode, req, flag}, {28'h0, snap});
      ce <= 1'b1;
      repeat (2000) if (flag !== 1'b1) @(posedge mclk_in);
      chk({31'h0, flag}, 32'h1);
      rdchk(POSITION_OFFSET, word[31:0]);
      rdchk(STATUS_OFFSET, 32'h0000_0006);
      rdchk(IRQ_STATUS_OFFSET, 32'h0000_0001);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, CTRL_OFFSET, 32'h0000_0000);
      chk({30'h0, servo_enable_output, flag}, 32'h0);
    end
    // Stalled amplifier, then abort with the abort event masked
    lag <= 4'hf;
    bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0001);
    bus(1'b1, CTRL_OFFSET, 32'h0000_0001);
    repeat (200) @(posedge mclk_in);
    chk({27'h0, servo_enable_output, mode, req, flag, irq}, 32'h0000_001c);
    rdchk(IRQ_STATUS_OFFSET, 32'h0000_0000);
    bus(1'b1, CTRL_OFFSET, 32'h0000_0000);
    chk({29'h0, servo_enable_output, mode, req}, 32'h0);
    rdchk(IRQ_STATUS_OFFSET, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0);
    rdchk(POSITION_OFFSET, word[31:0]);
    bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0003);
    chk({31'h0, irq}, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
